// ===== core/phy_basic_control_status.sv
// Contract
// - writing 1 to soft reset resets the device; bit self-clears when done
// - loopback bit set returns MAC data back toward the MAC
// - forced speed bits 13 and 6 set rate only while negotiation disabled
// - speed code 0 is 10, 1 is 100, 2 is 1000, 3 reserved
// - negotiation enable bit turns negotiation on, resets to one
// - bit 11 is read-only power-down state, reads zero after reset
// - isolate bit set isolates the MAC interface pins
// - software writes 1 to restart bit; device restarts negotiation
// - duplex bit selects full when 1, half when 0; resets full
// - collision test bit enables collision signal test
// - control register at offset zero, default value, low six bits read zero
// - status bits 14 to 11 read as fixed ability ones
// - status bit 8 reads one: gigabit extended status present
// - status bit 6 reads one: frames without preamble accepted
// - status bit 5 shows negotiation completion
// - remote fault bit sets on fault, cleared by status read
// - link bit latches low on loss; software reads twice
// - jabber bit sets on jabber, cleared by status read
// - status bit 3 reads one: negotiation capable
// - status bit 0 reads one: extended registers present
// - status register at offset one, default value, reserved bits read zero
module phy_basic_control_status
	import phy_ctrl_pkg::*;
#(
	parameter int RESET_CYCLES = SOFT_RESET_CYCLES
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  pclken,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [APB_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  power_down_state,
	input  wire logic                  negotiation_done,
	input  wire logic                  link_up,
	input  wire logic                  remote_fault,
	input  wire logic                  jabber_detect,
	output logic                       soft_reset_active,
	output logic                       loopback_enable,
	output logic      [1:0]            forced_speed,
	output logic                       forced_speed_active,
	output logic                       negotiation_enable,
	output logic                       isolate_enable,
	output logic                       negotiation_restart,
	output logic                       full_duplex,
	output logic                       collision_test_enable
);

	// ************************************************************
	// elaboration check
	// ************************************************************
	if (RESET_CYCLES < 1 || RESET_CYCLES > 65535) begin : g_bad_param
		$error("RESET_CYCLES out of range");
	end

	// ************************************************************
	// bus decode
	// ************************************************************
	logic        setup_rd;
	logic        access_wr;
	logic        hit_ctl;
	logic        hit_sts;
	logic [15:0] wdata;
	logic [15:0] status_word;
	logic [15:0] control_word;
	logic [15:0] rst_cnt_q;
	logic        link_q;
	logic        fault_q;
	logic        jabber_q;
	logic        neg_done_q;
	logic        pwd_q;

	// registered answer costs no wait state: pready is set at the setup edge, so it sits on the first access cycle
	assign setup_rd  = pclken && psel && !penable;
	assign access_wr = pclken && psel && penable && pready && pwrite;
	assign wdata     = pwdata[15:0];

	// address decode
	always_comb begin
		hit_ctl = 1'b0;
		hit_sts = 1'b0;
		if (paddr == ADDR_BASIC_CONTROL) begin
			hit_ctl = 1'b1;
		end else if (paddr == ADDR_BASIC_STATUS) begin
			hit_sts = 1'b1;
		end
	end

	// read-back images; reserved bits stay zero
	always_comb begin
		control_word                  = 16'h0000;
		control_word[CTL_SOFT_RESET]  = soft_reset_active;
		control_word[CTL_LOOPBACK]    = loopback_enable;
		control_word[CTL_SPEED_LSB]   = forced_speed[0];
		control_word[CTL_NEG_ENABLE]  = negotiation_enable;
		control_word[CTL_POWER_DOWN]  = pwd_q;
		control_word[CTL_ISOLATE]     = isolate_enable;
		control_word[CTL_NEG_RESTART] = negotiation_restart;
		control_word[CTL_DUPLEX]      = full_duplex;
		control_word[CTL_COLL_TEST]   = collision_test_enable;
		control_word[CTL_SPEED_MSB]   = forced_speed[1];
		status_word                       = 16'h0000;
		status_word[STS_ABILITY_100_FULL] = 1'b1;
		status_word[STS_ABILITY_100_HALF] = 1'b1;
		status_word[STS_ABILITY_10_FULL]  = 1'b1;
		status_word[STS_ABILITY_10_HALF]  = 1'b1;
		status_word[STS_GIG_EXT_STATUS]   = 1'b1;
		status_word[STS_NO_PREAMBLE]      = 1'b1;
		status_word[STS_NEG_DONE]         = neg_done_q;
		status_word[STS_REMOTE_FAULT]     = fault_q;
		status_word[STS_NEG_CAPABLE]      = 1'b1;
		status_word[STS_LINK_UP]          = link_q;
		status_word[STS_JABBER]           = jabber_q;
		status_word[STS_EXT_REGS]         = 1'b1;
	end

	// ************************************************************
	// apb answer
	// ************************************************************
	// snapshot taken at the setup edge, held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (pclken) begin
			if (setup_rd) begin
				pready  <= 1'b1;
				pslverr <= !(hit_ctl || hit_sts);
				if (pwrite || !(hit_ctl || hit_sts)) begin
					prdata <= 32'h0000_0000;
				end else if (hit_ctl) begin
					prdata <= {16'h0000, control_word};
				end else begin
					prdata <= {16'h0000, status_word};
				end
			end else begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// ************************************************************
	// control register
	// ************************************************************
	// soft reset returns every writable control field to its default
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loopback_enable       <= CONTROL_RESET[CTL_LOOPBACK];
			forced_speed          <= {CONTROL_RESET[CTL_SPEED_MSB], CONTROL_RESET[CTL_SPEED_LSB]};
			negotiation_enable    <= CONTROL_RESET[CTL_NEG_ENABLE];
			isolate_enable        <= CONTROL_RESET[CTL_ISOLATE];
			full_duplex           <= CONTROL_RESET[CTL_DUPLEX];
			collision_test_enable <= CONTROL_RESET[CTL_COLL_TEST];
		end else if (pclken) begin
			if (soft_reset_active) begin
				loopback_enable       <= CONTROL_RESET[CTL_LOOPBACK];
				forced_speed          <= {CONTROL_RESET[CTL_SPEED_MSB],
				                          CONTROL_RESET[CTL_SPEED_LSB]};
				negotiation_enable    <= CONTROL_RESET[CTL_NEG_ENABLE];
				isolate_enable        <= CONTROL_RESET[CTL_ISOLATE];
				full_duplex           <= CONTROL_RESET[CTL_DUPLEX];
				collision_test_enable <= CONTROL_RESET[CTL_COLL_TEST];
			end else if (access_wr && hit_ctl) begin
				loopback_enable       <= wdata[CTL_LOOPBACK];
				forced_speed          <= {wdata[CTL_SPEED_MSB], wdata[CTL_SPEED_LSB]};
				negotiation_enable    <= wdata[CTL_NEG_ENABLE];
				isolate_enable        <= wdata[CTL_ISOLATE];
				full_duplex           <= wdata[CTL_DUPLEX];
				collision_test_enable <= wdata[CTL_COLL_TEST];
			end
		end
	end

	// forced speed only matters with negotiation off; one cycle behind the bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			forced_speed_active <= !CONTROL_RESET[CTL_NEG_ENABLE];
		end else if (pclken) begin
			forced_speed_active <= !negotiation_enable;
		end
	end

	// soft reset: bit stays set while the count runs, then clears itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_reset_active <= 1'b0;
			rst_cnt_q         <= 16'h0000;
		end else if (pclken) begin
			if (soft_reset_active) begin
				if (rst_cnt_q == 16'(RESET_CYCLES - 1)) begin
					soft_reset_active <= 1'b0;
					rst_cnt_q         <= 16'h0000;
				end else begin
					rst_cnt_q <= rst_cnt_q + 16'h0001;
				end
			end else if (access_wr && hit_ctl && wdata[CTL_SOFT_RESET]) begin
				soft_reset_active <= 1'b1;
				rst_cnt_q         <= 16'h0000;
			end
		end
	end

	// restart is a one-cycle request; the negotiation engine takes it as a pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			negotiation_restart <= 1'b0;
		end else if (pclken) begin
			negotiation_restart <= access_wr && hit_ctl && !soft_reset_active
			                       && wdata[CTL_NEG_RESTART];
		end
	end

	// ************************************************************
	// status register
	// ************************************************************
	// live level status sampled into flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			neg_done_q <= STATUS_RESET[STS_NEG_DONE];
			pwd_q      <= CONTROL_RESET[CTL_POWER_DOWN];
		end else if (pclken) begin
			neg_done_q <= negotiation_done;
			pwd_q      <= power_down_state;
		end
	end

	// sticky events: a status read clears, but a new event in that cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q  <= STATUS_RESET[STS_REMOTE_FAULT];
			jabber_q <= STATUS_RESET[STS_JABBER];
		end else if (pclken) begin
			if (soft_reset_active) begin
				fault_q  <= 1'b0;
				jabber_q <= 1'b0;
			end else if (setup_rd && hit_sts && !pwrite) begin
				fault_q  <= remote_fault;
				jabber_q <= jabber_detect;
			end else begin
				fault_q  <= fault_q || remote_fault;
				jabber_q <= jabber_q || jabber_detect;
			end
		end
	end

	// link latches low; a read reloads the live level so the second read is valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_q <= STATUS_RESET[STS_LINK_UP];
		end else if (pclken) begin
			if (setup_rd && hit_sts && !pwrite) begin
				link_q <= link_up;
			end else if (!link_up) begin
				link_q <= 1'b0;
			end
		end
	end

endmodule

// ===== core/phy_ctrl_pkg.sv
package phy_ctrl_pkg;

	// ************************************************************
	// register map: word indexes, byte address is four times the index
	// ************************************************************
	localparam logic [3:0]  IDX_BASIC_CONTROL = 4'h0;
	localparam logic [3:0]  IDX_BASIC_STATUS  = 4'h1;
	localparam logic [11:0] ADDR_BASIC_CONTROL = {6'h00, IDX_BASIC_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_BASIC_STATUS  = {6'h00, IDX_BASIC_STATUS, 2'h0};
	localparam int          APB_ADDR_W         = 12;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [15:0] CONTROL_RESET = 16'h1140;
	localparam logic [15:0] STATUS_RESET  = 16'h7949;

	// ************************************************************
	// basic_control field positions
	// ************************************************************
	localparam int CTL_SOFT_RESET  = 15;
	localparam int CTL_LOOPBACK    = 14;
	localparam int CTL_SPEED_LSB   = 13;
	localparam int CTL_NEG_ENABLE  = 12;
	localparam int CTL_POWER_DOWN  = 11;
	localparam int CTL_ISOLATE     = 10;
	localparam int CTL_NEG_RESTART = 9;
	localparam int CTL_DUPLEX      = 8;
	localparam int CTL_COLL_TEST   = 7;
	localparam int CTL_SPEED_MSB   = 6;

	// ************************************************************
	// basic_status field positions
	// ************************************************************
	localparam int STS_ABILITY_100_FULL = 14;
	localparam int STS_ABILITY_100_HALF = 13;
	localparam int STS_ABILITY_10_FULL  = 12;
	localparam int STS_ABILITY_10_HALF  = 11;
	localparam int STS_GIG_EXT_STATUS   = 8;
	localparam int STS_NO_PREAMBLE      = 6;
	localparam int STS_NEG_DONE         = 5;
	localparam int STS_REMOTE_FAULT     = 4;
	localparam int STS_NEG_CAPABLE      = 3;
	localparam int STS_LINK_UP          = 2;
	localparam int STS_JABBER           = 1;
	localparam int STS_EXT_REGS         = 0;

	// ************************************************************
	// forced speed codes and timing
	// ************************************************************
	typedef enum logic [1:0] {
		SPEED_10   = 2'h0,
		SPEED_100  = 2'h1,
		SPEED_1000 = 2'h2,
		SPEED_RSVD = 2'h3
	} speed_code_t;

	localparam int SOFT_RESET_CYCLES = 16;

endpackage

// ===== tb/phy_basic_control_status_props.sv
// **********
// register bank checker
// **********
module phy_basic_control_status_props
	import phy_ctrl_pkg::*;
#(
	parameter int RESET_CYCLES = SOFT_RESET_CYCLES
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        soft_reset_active,
	input wire logic [1:0]  forced_speed,
	input wire logic        forced_speed_active,
	input wire logic        negotiation_enable,
	input wire logic        negotiation_restart,
	input wire logic        full_duplex
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       done;
	logic       wr_ok;
	logic [7:0] sr_cnt_q;
	// finished transfer; control writes that are not swallowed by soft reset
	assign done = psel && penable && pready;
	assign wr_ok = done && pwrite && paddr == ADDR_BASIC_CONTROL && !soft_reset_active;
	// cycles spent in the current soft reset, too wide to unroll as a repetition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sr_cnt_q <= 8'h00;
		else
			sr_cnt_q <= soft_reset_active ? sr_cnt_q + 8'h01 : 8'h00;
	end
	chk_ctl_low_zero: assert property (done && !pwrite && paddr == ADDR_BASIC_CONTROL |->
		prdata[5:0] == 6'h00 && prdata[31:16] == 16'h0000) else $error("control low bits set");
	chk_sts_fixed_bits: assert property (done && !pwrite && paddr == ADDR_BASIC_STATUS |->
		(prdata & 32'hffffffc9) == 32'h00007949) else $error("status fixed bits wrong");
	chk_sr_start: assert property (wr_ok && pwdata[15] |=> soft_reset_active)
		else $error("soft reset did not start");
	chk_sr_length: assert property ($fell(soft_reset_active) |-> sr_cnt_q == RESET_CYCLES)
		else $error("soft reset length wrong");
	chk_restart_pulse: assert property (wr_ok && pwdata[9] |=> negotiation_restart ##1 !negotiation_restart)
		else $error("restart pulse wrong");
	chk_speed_field: assert property (wr_ok && !pwdata[15] |=> forced_speed == $past({pwdata[6], pwdata[13]}))
		else $error("forced speed not written");
	chk_mode_fields: assert property (wr_ok && !pwdata[15] |=>
		{negotiation_enable, full_duplex} == $past({pwdata[12], pwdata[8]})) else $error("mode bits not written");
	chk_forced_gate: assert property ($stable(negotiation_enable) |-> forced_speed_active != negotiation_enable)
		else $error("forced speed gate wrong");
	chk_unmapped_err: assert property (pready |->
		pslverr == (paddr != ADDR_BASIC_CONTROL && paddr != ADDR_BASIC_STATUS)) else $error("slave error wrong");
	cov_soft_reset: cover property (wr_ok && pwdata[15]);
	cov_link_up: cover property (done && !pwrite && paddr == ADDR_BASIC_STATUS && prdata[2]);
	cov_unmapped: cover property (pready && pslverr);
endmodule

bind phy_basic_control_status phy_basic_control_status_props #(.RESET_CYCLES(RESET_CYCLES)) props_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.soft_reset_active(soft_reset_active), .forced_speed(forced_speed),
	.forced_speed_active(forced_speed_active), .negotiation_enable(negotiation_enable),
	.negotiation_restart(negotiation_restart), .full_duplex(full_duplex)
);

// ===== tb/mgmt_master.sv
// **********
// station manager on the register bus
// **********
module mgmt_master (
	input  wire logic        pclk,
	input  wire logic        pready,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// one transfer; released lines show the inverse so stale data cannot pass
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// ===== tb/test_phy_basic_control_status.sv
// **********
// register bank bench
// **********
module test_phy_basic_control_status
	import phy_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [32:0] ALL = '1;
	typedef struct packed {logic [32:0] m; logic [32:0] v;} note_t;
	logic        pclk = 1'b0, presetn = 1'b0, power_down_state = 1'b0, negotiation_done = 1'b0;
	logic        link_up = 1'b0, remote_fault = 1'b0, jabber_detect = 1'b0, pclken = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr, soft_reset_active, loopback_enable;
	logic        forced_speed_active, negotiation_enable, isolate_enable, negotiation_restart;
	logic        full_duplex, collision_test_enable;
	logic [1:0]  forced_speed, c;
	logic [11:0] paddr;
	logic [15:0] d;
	logic [31:0] pwdata, prdata, seed = 32'h33b498e0;
	note_t       notes[$], cur;
	int          miscompares = 0, total_checks = 0;
	phy_basic_control_status #(.RESET_CYCLES(4)) phy_basic_control_status_i (
		.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_down_state(power_down_state), .link_up(link_up),
		.negotiation_done(negotiation_done), .remote_fault(remote_fault),
		.jabber_detect(jabber_detect), .soft_reset_active(soft_reset_active),
		.loopback_enable(loopback_enable), .forced_speed(forced_speed),
		.forced_speed_active(forced_speed_active), .negotiation_enable(negotiation_enable),
		.isolate_enable(isolate_enable), .negotiation_restart(negotiation_restart),
		.full_duplex(full_duplex), .collision_test_enable(collision_test_enable));
	mgmt_master mgmt_master_i (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	always #2.5 pclk = ~pclk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// compare helpers, one per kind of result
	task automatic fail(input logic [32:0] g, input logic [32:0] e);
		miscompares++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
	endtask
	task automatic cmp_read(input logic [32:0] g, input note_t n);
		total_checks++;
		if ((g & n.m) !== (n.v & n.m)) fail(g, n.v);
	endtask
	task automatic cmp_port(input logic [32:0] g, input logic [32:0] e);
		total_checks++;
		if (g !== e) fail(g, e);
	endtask
	// every transfer leaves a note of {slave error, read data}
	task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
		notes.push_back('{m, e});
		mgmt_master_i.xfer(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic err);
		notes.push_back('{ALL, {err, 32'h0}});
		mgmt_master_i.xfer(1'b1, a, {16'h0, v});
	endtask
	task automatic summarize();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// answer monitor: oldest note against each completed transfer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && notes.size() != 0) begin
			cur = notes.pop_front();
			cmp_read({pslverr, prdata}, cur);
		end
	end
	// hang guard, far beyond the roughly 120 cycles of the run
	initial begin
		#20000;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		cmp_port({negotiation_enable, full_duplex, forced_speed, forced_speed_active}, 33'h1c);
		rd(ADDR_BASIC_CONTROL, 33'h1140, ALL);
		rd(ADDR_BASIC_STATUS, 33'h7949, ALL);
		rd(12'h008, 33'h100000000, ALL);
		// every speed code twice, other fields random
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			c = i[1:0];
			d = (seed[15:0] & 16'h5580) | {2'h0, c[0], 6'h00, c[1], 6'h00};
			power_down_state <= seed[20];
			wr(ADDR_BASIC_CONTROL, d, 1'b0);
			@(posedge pclk);
			#1;
			cmp_port({forced_speed, negotiation_enable, full_duplex, loopback_enable, isolate_enable,
				collision_test_enable, forced_speed_active}, {c, d[12], d[8], d[14], d[10], d[7], !d[12]});
			rd(ADDR_BASIC_CONTROL, {17'h0, d | {4'h0, power_down_state, 11'h000}}, ALL);
		end
		wr(12'h00c, 16'hffff, 1'b1);
		rd(ADDR_BASIC_CONTROL, {17'h0, d | {4'h0, power_down_state, 11'h000}}, ALL);
		wr(ADDR_BASIC_CONTROL, 16'h1340, 1'b0);
		#1;
		cmp_port(negotiation_restart, 33'h1);
		@(posedge pclk);
		#1;
		cmp_port(negotiation_restart, 33'h0);
		// soft reset swallows a write made while it runs
		wr(ADDR_BASIC_CONTROL, 16'h8000, 1'b0);
		wr(ADDR_BASIC_CONTROL, 16'h0000, 1'b0);
		for (int i = 0; i < 32 && soft_reset_active !== 1'b0; i++) @(posedge pclk);
		rd(ADDR_BASIC_CONTROL, {17'h0, 16'h1140 | {4'h0, power_down_state, 11'h000}}, ALL);
		{link_up, negotiation_done, remote_fault, jabber_detect} <= 4'hf;
		@(posedge pclk);
		{remote_fault, jabber_detect} <= 2'h0;
		repeat (2) @(posedge pclk);
		rd(ADDR_BASIC_STATUS, 33'h797b, ALL ^ 33'h4);
		rd(ADDR_BASIC_STATUS, 33'h796d, ALL);
		rd(ADDR_BASIC_STATUS, 33'h796d, ALL);
		link_up <= 1'b0;
		repeat (2) @(posedge pclk);
		link_up <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(ADDR_BASIC_STATUS, 33'h7969, ALL);
		rd(ADDR_BASIC_STATUS, 33'h796d, ALL);
		// a fault pulse while the clock enable is low must not be seen
		pclken <= 1'b0;
		remote_fault <= 1'b1;
		@(posedge pclk);
		pclken <= 1'b1;
		remote_fault <= 1'b0;
		rd(ADDR_BASIC_STATUS, 33'h796d, ALL);
		repeat (2) @(posedge pclk);
		cmp_port(33'(notes.size()), 33'h0);
		summarize();
	end
endmodule
